//--- design/ofr_map.vh
`ifndef OFR_MAP_VH
`define OFR_MAP_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define OFR_CMD_PAGE 8'h00
`define OFR_CMD_UV_LIM 8'h44
`define OFR_CMD_UV_RESP 8'h45
`define OFR_CMD_OC_LIM 8'h46
`define OFR_CMD_OC_RESP 8'h47

// ----------------------------------------
// Reset values
// ----------------------------------------
`define OFR_UV_RESP_RST 8'h84
`define OFR_OC_LIM_RST 16'h012c
`define OFR_OC_RESP_RST 8'hc4
`define OFR_UV_LIM_RST 16'h0000

// ----------------------------------------
// Per-page word layout and field positions
// ----------------------------------------
`define OFR_WORD_W 48
`define OFR_SEL_UV_RESP 2'h0
`define OFR_SEL_OC_LIM 2'h1
`define OFR_SEL_OC_RESP 2'h2
`define OFR_SEL_UV_LIM 2'h3
`define OFR_W_UV_RESP 7:0
`define OFR_W_OC_LIM 23:8
`define OFR_W_OC_RESP 31:24
`define OFR_W_UV_LIM 47:32
`define OFR_F_MODE 7:6
`define OFR_F_RETRY 5:3
`define OFR_F_DELAY 2:0
`define OFR_UV_MODE_OFF 2'h2
`define OFR_OC_MODE_OFF 2'h3
`define OFR_RETRY_ALWAYS 3'h7
`define OFR_DELAY_LONG 3'h7

// ----------------------------------------
// Timing
// ----------------------------------------
`define OFR_CLK_MHZ 200
`define OFR_RETRY_STEP_US 25000
`define OFR_RETRY_LONG_US 175000

`endif

//--- design/ofr_cfg_mem.v
`timescale 1ns/1ps
`include "ofr_map.vh"

module ofr_cfg_mem #(
    parameter NOUT = 2,
    parameter PW = 1
) (
    input wire clk,
    input wire reset,
    input wire wrEn,
    input wire [PW-1:0] wrPage,
    input wire [1:0] wrSel,
    input wire [15:0] wrData,
    output wire [NOUT*`OFR_WORD_W-1:0] cfgFlat
);
    genvar p;
    generate
        for (p = 0; p < NOUT; p = p + 1) begin : gPage
            reg [`OFR_WORD_W-1:0] word_reg;
            wire pageHit = {{(32-PW){1'b0}}, wrPage} == p;
            always @(posedge clk) begin
                if (reset) begin
                    word_reg <= {`OFR_UV_LIM_RST, `OFR_OC_RESP_RST,
                                 `OFR_OC_LIM_RST, `OFR_UV_RESP_RST};
                end else if (wrEn && pageHit) begin
                    case (wrSel)
                        `OFR_SEL_UV_RESP:
                            word_reg[`OFR_W_UV_RESP] <= wrData[7:0];
                        `OFR_SEL_OC_LIM:
                            word_reg[`OFR_W_OC_LIM] <= wrData;
                        `OFR_SEL_OC_RESP:
                            word_reg[`OFR_W_OC_RESP] <= wrData[7:0];
                        default: word_reg[`OFR_W_UV_LIM] <= wrData;
                    endcase
                end
            end
            assign cfgFlat[p*`OFR_WORD_W +: `OFR_WORD_W] = word_reg;
        end
    endgenerate
endmodule // ofr_cfg_mem

//--- design/ofr_fault_resp.v
`timescale 1ns/1ps
`include "ofr_map.vh"

module ofr_fault_resp #(
    parameter NOUT = 2,
    parameter PW = 1,
    parameter [6:0] SLAVE_ADDR = 7'h40,
    parameter [31:0] STEP_CYCLES = `OFR_RETRY_STEP_US * `OFR_CLK_MHZ,
    parameter [31:0] LONG_CYCLES = `OFR_RETRY_LONG_US * `OFR_CLK_MHZ
) (
    input wire clk,
    input wire reset,
    input wire sclIn,
    input wire sdaIn,
    output reg sdaOut,
    output reg sdaOe,
    output reg alertLineNOut,
    output reg alertLineNOe,
    input wire [NOUT*16-1:0] voutMv,
    input wire [NOUT*16-1:0] ioutSum,
    input wire [NOUT-1:0] undercurrentDet,
    input wire [NOUT-1:0] rampActive,
    input wire [NOUT-1:0] railOnCmd,
    input wire [NOUT-1:0] otherShutdown,
    output wire [NOUT-1:0] outputEnable,
    output wire [NOUT-1:0] uvStatus,
    output wire [NOUT-1:0] ocStatus
);
    localparam [4:0] B_IDLE = 5'h01;
    localparam [4:0] B_RX = 5'h02;
    localparam [4:0] B_RACK = 5'h04;
    localparam [4:0] B_TX = 5'h08;
    localparam [4:0] B_TACK = 5'h10;
    localparam [3:0] R_OFF = 4'h1;
    localparam [3:0] R_RUN = 4'h2;
    localparam [3:0] R_WAIT = 4'h4;
    localparam [3:0] R_LATCH = 4'h8;

    // ----------------------------------------
    // Pin sampling
    // ----------------------------------------
    // A level is taken once stages two and three agree, so one-cycle
    // glitches on the slow bus never reach the byte logic.
    reg [1:0] pinS1_reg;
    reg [1:0] pinS2_reg;
    reg [1:0] pinS3_reg;
    reg [1:0] pinF_reg;
    reg [1:0] pinFPrev_reg;
    always @(posedge clk) begin
        if (reset) begin
            pinS1_reg <= 2'h3;
            pinS2_reg <= 2'h3;
            pinS3_reg <= 2'h3;
            pinF_reg <= 2'h3;
            pinFPrev_reg <= 2'h3;
        end else begin
            pinS1_reg <= {sclIn, sdaIn};
            pinS2_reg <= pinS1_reg;
            pinS3_reg <= pinS2_reg;
            if (pinS2_reg == pinS3_reg)
                pinF_reg <= pinS3_reg;
            pinFPrev_reg <= pinF_reg;
        end
    end
    wire sclF = pinF_reg[1];
    wire sdaF = pinF_reg[0];
    wire sclRise = sclF && !pinFPrev_reg[1];
    wire sclFall = !sclF && pinFPrev_reg[1];
    wire startEv = sclF && pinFPrev_reg[1] && !sdaF && pinFPrev_reg[0];
    wire stopEv = sclF && pinFPrev_reg[1] && sdaF && !pinFPrev_reg[0];

    // ----------------------------------------
    // Register store
    // ----------------------------------------
    reg memWr_reg;
    reg [1:0] memSel_reg;
    reg [15:0] memData_reg;
    reg [PW-1:0] page_reg;
    wire [NOUT*`OFR_WORD_W-1:0] cfgFlat;

    ofr_cfg_mem #(.NOUT(NOUT), .PW(PW)) uMem (
        .clk(clk),
        .reset(reset),
        .wrEn(memWr_reg),
        .wrPage(page_reg),
        .wrSel(memSel_reg),
        .wrData(memData_reg),
        .cfgFlat(cfgFlat)
    );

    function [15:0] readVal;
        input [7:0] cmd;
        input [`OFR_WORD_W-1:0] w;
        input [PW-1:0] pg;
        begin
            if (cmd == `OFR_CMD_PAGE)
                readVal = {{(16-PW){1'b0}}, pg};
            else if (cmd == `OFR_CMD_UV_RESP)
                readVal = {8'h00, w[`OFR_W_UV_RESP]};
            else if (cmd == `OFR_CMD_OC_LIM)
                readVal = w[`OFR_W_OC_LIM];
            else if (cmd == `OFR_CMD_OC_RESP)
                readVal = {8'h00, w[`OFR_W_OC_RESP]};
            else if (cmd == `OFR_CMD_UV_LIM)
                readVal = w[`OFR_W_UV_LIM];
            else
                readVal = 16'hffff;
        end
    endfunction

    function isWord;
        input [7:0] cmd;
        begin
            isWord = (cmd == `OFR_CMD_OC_LIM) || (cmd == `OFR_CMD_UV_LIM);
        end
    endfunction

    // ----------------------------------------
    // Management bus slave
    // ----------------------------------------
    reg [4:0] busSt_reg;
    reg [3:0] bitCnt_reg;
    reg [1:0] byteIdx_reg;
    reg [7:0] rxShift_reg;
    reg [7:0] txShift_reg;
    reg [7:0] cmd_reg;
    reg [7:0] lowByte_reg;
    reg rwBit_reg;
    reg rdIdx_reg;
    reg ackSeen_reg;

    wire [15:0] rdWord = readVal(cmd_reg,
        cfgFlat[page_reg*`OFR_WORD_W +: `OFR_WORD_W], page_reg);
    wire [7:0] rdByte = rdIdx_reg ? rdWord[15:8] : rdWord[7:0];
    wire txLoad = sclFall && ((busSt_reg == B_RACK && rwBit_reg) ||
                              (busSt_reg == B_TACK && ackSeen_reg));
    wire [1:0] cmdSel = cmd_reg == `OFR_CMD_UV_RESP ? `OFR_SEL_UV_RESP :
        cmd_reg == `OFR_CMD_OC_LIM ? `OFR_SEL_OC_LIM :
        cmd_reg == `OFR_CMD_OC_RESP ? `OFR_SEL_OC_RESP : `OFR_SEL_UV_LIM;
    wire cmdMapped = cmd_reg == `OFR_CMD_UV_RESP ||
        cmd_reg == `OFR_CMD_OC_LIM || cmd_reg == `OFR_CMD_OC_RESP ||
        cmd_reg == `OFR_CMD_UV_LIM;

    always @(posedge clk) begin
        if (reset) begin
            busSt_reg <= B_IDLE;
            bitCnt_reg <= 4'h0;
            byteIdx_reg <= 2'h0;
            rxShift_reg <= 8'h00;
            txShift_reg <= 8'h00;
            cmd_reg <= 8'h00;
            lowByte_reg <= 8'h00;
            rwBit_reg <= 1'b0;
            rdIdx_reg <= 1'b0;
            ackSeen_reg <= 1'b0;
            page_reg <= {PW{1'b0}};
            memWr_reg <= 1'b0;
            memSel_reg <= 2'h0;
            memData_reg <= 16'h0000;
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
        end else begin
            memWr_reg <= 1'b0;
            if (txLoad) begin
                txShift_reg <= {rdByte[6:0], 1'b0};
                sdaOe <= ~rdByte[7];
                bitCnt_reg <= 4'h1;
                rdIdx_reg <= 1'b1;
                busSt_reg <= B_TX;
            end else if (startEv) begin
                busSt_reg <= B_RX;
                bitCnt_reg <= 4'h0;
                byteIdx_reg <= 2'h0;
                sdaOe <= 1'b0;
            end else if (stopEv) begin
                busSt_reg <= B_IDLE;
                sdaOe <= 1'b0;
            end else begin
                case (busSt_reg)
                    B_RX: begin
                        if (sclRise) begin
                            rxShift_reg <= {rxShift_reg[6:0], sdaF};
                            bitCnt_reg <= bitCnt_reg + 4'h1;
                        end else if (sclFall && bitCnt_reg == 4'h8) begin
                            bitCnt_reg <= 4'h0;
                            busSt_reg <= B_RACK;
                            sdaOe <= 1'b1;
                            if (byteIdx_reg == 2'h0) begin
                                rwBit_reg <= rxShift_reg[0];
                                rdIdx_reg <= 1'b0;
                                if (rxShift_reg[7:1] != SLAVE_ADDR) begin
                                    busSt_reg <= B_IDLE;
                                    sdaOe <= 1'b0;
                                end
                            end else if (byteIdx_reg == 2'h1) begin
                                cmd_reg <= rxShift_reg;
                            end else if (byteIdx_reg == 2'h2) begin
                                lowByte_reg <= rxShift_reg;
                                if (cmd_reg == `OFR_CMD_PAGE &&
                                    {24'h0, rxShift_reg} < NOUT)
                                    page_reg <= rxShift_reg[PW-1:0];
                                if (cmdMapped && !isWord(cmd_reg)) begin
                                    memWr_reg <= 1'b1;
                                    memSel_reg <= cmdSel;
                                    memData_reg <= {8'h00, rxShift_reg};
                                end
                            end else if (cmdMapped && isWord(cmd_reg)) begin
                                memWr_reg <= 1'b1;
                                memSel_reg <= cmdSel;
                                memData_reg <= {rxShift_reg, lowByte_reg};
                            end
                        end
                    end
                    B_RACK: begin
                        if (sclFall) begin
                            if (byteIdx_reg != 2'h3)
                                byteIdx_reg <= byteIdx_reg + 2'h1;
                            sdaOe <= 1'b0;
                            busSt_reg <= B_RX;
                        end
                    end
                    B_TX: begin
                        if (sclFall) begin
                            if (bitCnt_reg == 4'h8) begin
                                sdaOe <= 1'b0;
                                busSt_reg <= B_TACK;
                            end else begin
                                sdaOe <= ~txShift_reg[7];
                                txShift_reg <= {txShift_reg[6:0], 1'b0};
                                bitCnt_reg <= bitCnt_reg + 4'h1;
                            end
                        end
                    end
                    B_TACK: begin
                        if (sclRise)
                            ackSeen_reg <= ~sdaF;
                        else if (sclFall)
                            busSt_reg <= B_IDLE;
                    end
                    default: begin
                        sdaOe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Fault response per output
    // ----------------------------------------
    // Unsupported action codes fall back to continue; the host is
    // expected never to write them.
    function [31:0] delayCycles;
        input [2:0] code;
        begin
            if (code == `OFR_DELAY_LONG)
                delayCycles = LONG_CYCLES;
            else
                delayCycles = STEP_CYCLES * {29'h0, code};
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < NOUT; g = g + 1) begin : gOut
            wire [`OFR_WORD_W-1:0] cfg = cfgFlat[g*`OFR_WORD_W +: `OFR_WORD_W];
            wire [7:0] uvAct = cfg[`OFR_W_UV_RESP];
            wire [7:0] ocAct = cfg[`OFR_W_OC_RESP];
            reg [3:0] st_reg;
            reg [31:0] timer_reg;
            reg en_reg;
            reg uvSt_reg;
            reg ocSt_reg;
            wire running = st_reg == R_RUN;
            wire uvTrip = running && !rampActive[g] &&
                voutMv[g*16 +: 16] < cfg[`OFR_W_UV_LIM];
            wire ocTrip = running && (ioutSum[g*16 +: 16] >
                cfg[`OFR_W_OC_LIM] || undercurrentDet[g]);
            wire uvOff = uvTrip &&
                uvAct[`OFR_F_MODE] == `OFR_UV_MODE_OFF;
            wire ocOff = ocTrip &&
                ocAct[`OFR_F_MODE] == `OFR_OC_MODE_OFF;
            wire [7:0] act = ocOff ? ocAct : uvAct;
            always @(posedge clk) begin
                if (reset) begin
                    st_reg <= R_OFF;
                    timer_reg <= 32'h0;
                    en_reg <= 1'b0;
                    uvSt_reg <= 1'b0;
                    ocSt_reg <= 1'b0;
                end else begin
                    uvSt_reg <= uvTrip | (uvSt_reg & railOnCmd[g]);
                    ocSt_reg <= ocTrip | (ocSt_reg & railOnCmd[g]);
                    en_reg <= 1'b0;
                    case (st_reg)
                        R_OFF: begin
                            if (railOnCmd[g] && !otherShutdown[g]) begin
                                st_reg <= R_RUN;
                                en_reg <= 1'b1;
                            end
                        end
                        R_RUN: begin
                            if (!railOnCmd[g]) begin
                                st_reg <= R_OFF;
                            end else if (otherShutdown[g]) begin
                                st_reg <= R_LATCH;
                            end else if (uvOff || ocOff) begin
                                if (act[`OFR_F_RETRY] ==
                                    `OFR_RETRY_ALWAYS) begin
                                    st_reg <= R_WAIT;
                                    timer_reg <= delayCycles(
                                        act[`OFR_F_DELAY]);
                                end else begin
                                    st_reg <= R_LATCH;
                                end
                            end else begin
                                en_reg <= 1'b1;
                            end
                        end
                        R_WAIT: begin
                            if (!railOnCmd[g]) begin
                                st_reg <= R_OFF;
                            end else if (otherShutdown[g]) begin
                                st_reg <= R_LATCH;
                            end else if (timer_reg == 32'h0) begin
                                st_reg <= R_RUN;
                                en_reg <= 1'b1;
                            end else begin
                                timer_reg <= timer_reg - 32'h1;
                            end
                        end
                        default: begin
                            if (!railOnCmd[g])
                                st_reg <= R_OFF;
                        end
                    endcase
                end
            end
            assign outputEnable[g] = en_reg;
            assign uvStatus[g] = uvSt_reg;
            assign ocStatus[g] = ocSt_reg;
        end
    endgenerate

    // Alert held low while any status bit stands
    always @(posedge clk) begin
        if (reset) begin
            alertLineNOut <= 1'b0;
            alertLineNOe <= 1'b0;
        end else begin
            alertLineNOut <= 1'b0;
            alertLineNOe <= |{uvStatus, ocStatus};
        end
    end
endmodule // ofr_fault_resp

//--- bench/ofr_fault_resp_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checks on output 0, the bus and alert pins, and all outputs after reset
// ----------------------------------------
module ofr_fault_resp_asserts #(
    parameter NOUT = 2
) (
    input wire clk,
    input wire reset,
    input wire sdaOut,
    input wire sdaOe,
    input wire alertLineNOut,
    input wire alertLineNOe,
    input wire [NOUT-1:0] undercurrentDet,
    input wire [NOUT-1:0] rampActive,
    input wire [NOUT-1:0] railOnCmd,
    input wire [NOUT-1:0] otherShutdown,
    input wire [NOUT-1:0] outputEnable,
    input wire [NOUT-1:0] uvStatus,
    input wire [NOUT-1:0] ocStatus
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire anyFault = |{uvStatus, ocStatus};

    alert_follow_a: assert property (1'b1 |=>
        alertLineNOe == $past(anyFault))
        else $error("alert does not track status");
    drive_low_a: assert property (!sdaOut && !alertLineNOut)
        else $error("open-drain data not low");
    sticky_oc_a: assert property (ocStatus[0] && railOnCmd[0] |=>
        ocStatus[0])
        else $error("status lost while rail on");
    uv_masked_a: assert property ($rose(uvStatus[0]) |->
        $past(!rampActive[0] && outputEnable[0]))
        else $error("undervoltage seen while masked");
    off_cmd_a: assert property (!railOnCmd[0] |=> !outputEnable[0])
        else $error("rail stays on when commanded off");
    other_off_a: assert property (otherShutdown[0] |=> !outputEnable[0])
        else $error("rail stays on after other fault");
    uc_trip_a: assert property (outputEnable[0] && railOnCmd[0] &&
        undercurrentDet[0] |=> ocStatus[0])
        else $error("undercurrent not flagged");
    drop_cause_a: assert property ($fell(outputEnable[0]) |->
        uvStatus[0] || ocStatus[0] ||
        $past(!railOnCmd[0] || otherShutdown[0]))
        else $error("rail dropped without cause");
    restart_a: assert property ($rose(outputEnable[0]) |->
        $past(railOnCmd[0]))
        else $error("restart without on command");
    rail_up_a: assert property (!railOnCmd[0] ##1
        (railOnCmd[0] && !otherShutdown[0]) |=> outputEnable[0])
        else $error("rail did not start");
    quiet_reset_a: assert property (disable iff (1'b0) reset |=>
        !sdaOe && !alertLineNOe && !outputEnable && !anyFault)
        else $error("outputs active after reset");

    cover property (!outputEnable[0] ##1 outputEnable[0] && ocStatus[0]);
    cover property ($rose(uvStatus[0]));
    cover property ($rose(ocStatus[0]) ##1 outputEnable[0]);
endmodule // ofr_fault_resp_asserts

bind ofr_fault_resp ofr_fault_resp_asserts #(.NOUT(NOUT)) chk (
    .clk(clk), .reset(reset), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .alertLineNOut(alertLineNOut), .alertLineNOe(alertLineNOe),
    .undercurrentDet(undercurrentDet), .rampActive(rampActive),
    .railOnCmd(railOnCmd), .otherShutdown(otherShutdown),
    .outputEnable(outputEnable), .uvStatus(uvStatus), .ocStatus(ocStatus)
);

//--- bench/ofr_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Management bus host
// ----------------------------------------
module ofr_host_model #(
    parameter [6:0] ADDR = 7'h40
) (
    output reg scl,
    output reg sdaLow,
    input wire sdaWire
);
    // Quarter of the 125 ns bus clock; clock stands high between frames
    localparam real Q = 31.25;
    integer nackCount = 0;
    reg [7:0] junk;
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    task bitIo(input b, output r);
        begin
            #Q sdaLow = !b;
            #Q scl = 1'b1;
            #Q r = sdaWire;
            #Q scl = 1'b0;
        end
    endtask
    // Mode 0 expects the device to acknowledge, 1 host acks, 2 host nacks
    task xfer(input [7:0] dOut, input [1:0] mode, output [7:0] dIn);
        integer k;
        reg a;
        begin
            for (k = 7; k >= 0; k = k - 1)
                bitIo(dOut[k], dIn[k]);
            bitIo(mode != 2'd1, a);
            if (mode == 2'd0 && a)
                nackCount = nackCount + 1;
        end
    endtask
    // Also serves as repeated start from a low clock
    task start;
        begin
            #Q sdaLow = 1'b0;
            #Q scl = 1'b1;
            #Q sdaLow = 1'b1;
            #Q scl = 1'b0;
        end
    endtask
    task stop;
        begin
            #Q sdaLow = 1'b1;
            #Q scl = 1'b1;
            #Q sdaLow = 1'b0;
            #Q;
        end
    endtask
    task wrReg(input [7:0] cmd, input [15:0] val, input integer nb);
        begin
            start;
            xfer({ADDR, 1'b0}, 2'd0, junk);
            xfer(cmd, 2'd0, junk);
            xfer(val[7:0], 2'd0, junk);
            if (nb == 2)
                xfer(val[15:8], 2'd0, junk);
            stop;
        end
    endtask
    task rdReg(input [7:0] cmd, output [15:0] val);
        begin
            start;
            xfer({ADDR, 1'b0}, 2'd0, junk);
            xfer(cmd, 2'd0, junk);
            start;
            xfer({ADDR, 1'b1}, 2'd0, junk);
            xfer(8'hff, 2'd1, val[7:0]);
            xfer(8'hff, 2'd2, val[15:8]);
            stop;
        end
    endtask
endmodule // ofr_host_model

//--- bench/tb_ofr_fault_resp.sv
`timescale 1ns/1ps
// ----------------------------------------
// Register and fault response bench
// ----------------------------------------
module tb_ofr_fault_resp;
    reg clk = 1'b0;
    reg reset = 1'b1;
    reg [31:0] voutMv = 32'h0fff0fff;
    reg [31:0] ioutSum = 32'h00000000;
    reg [1:0] undercurrentDet = 2'h0;
    reg [1:0] rampActive = 2'h0;
    reg [1:0] railOnCmd = 2'h0;
    reg [1:0] otherShutdown = 2'h0;
    wire scl, hostLow, sdaOut, sdaOe, alertLineNOut, alertLineNOe;
    wire [1:0] outputEnable, uvStatus, ocStatus;
    wire sdaWire = (sdaOe ? sdaOut : 1'b1) & !hostLow;
    integer fail_count = 0;
    integer samples_checked = 0;
    integer i, n;
    reg [15:0] d;

    always #2.5 clk = ~clk;

    ofr_host_model host (.scl(scl), .sdaLow(hostLow), .sdaWire(sdaWire));

    // Short retry steps keep the run brief
    ofr_fault_resp #(.STEP_CYCLES(32'd10), .LONG_CYCLES(32'd70)) dut (
        .clk(clk), .reset(reset), .sclIn(scl), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .alertLineNOut(alertLineNOut),
        .alertLineNOe(alertLineNOe), .voutMv(voutMv), .ioutSum(ioutSum),
        .undercurrentDet(undercurrentDet), .rampActive(rampActive),
        .railOnCmd(railOnCmd), .otherShutdown(otherShutdown),
        .outputEnable(outputEnable), .uvStatus(uvStatus), .ocStatus(ocStatus)
    );

    task complete_run;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("ERROR %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer k);
        begin
            repeat (k) @(posedge clk);
            #1;
        end
    endtask
    // Rail off then on clears sticky status and restarts output 0
    task railCycle;
        begin
            tick(1);
            railOnCmd[0] = 1'b0;
            tick(2);
            railOnCmd[0] = 1'b1;
            tick(2);
        end
    endtask
    task retry(input [7:0] act, input integer dly);
        begin
            host.wrReg(8'h47, {8'h00, act}, 1);
            railCycle;
            undercurrentDet[0] = 1'b1;
            tick(1);
            undercurrentDet[0] = 1'b0;
            chk({ocStatus[0], outputEnable[0]}, 16'h0002);
            n = 0;
            while (outputEnable[0] !== 1'b1) begin
                tick(1);
                n = n + 1;
                if (n > 300) begin
                    $display("ERROR %0t: enable did not return", $time);
                    fail_count = fail_count + 1;
                    complete_run;
                end
            end
            chk(n >= dly + 1 && n <= dly + 3, 16'h0001);
        end
    endtask

    initial begin
        tick(4);
        reset = 1'b0;
        tick(8);
        for (i = 0; i < 2; i = i + 1) begin
            host.wrReg(8'h00, i[15:0], 1);
            host.rdReg(8'h45, d);
            chk(d, 16'h0084);
            host.rdReg(8'h46, d);
            chk(d, 16'h012c);
            host.rdReg(8'h47, d);
            chk(d, 16'h00c4);
        end
        host.wrReg(8'h46, 16'habcd, 2);
        host.rdReg(8'h46, d);
        chk(d, 16'habcd);
        host.wrReg(8'h00, 16'h0000, 1);
        host.rdReg(8'h46, d);
        chk(d, 16'h012c);
        $display("register test done");
        tick(1);
        railOnCmd = 2'h3;
        tick(2);
        chk(outputEnable, 16'h0003);
        ioutSum[15:0] = 16'h012c;
        tick(3);
        chk(ocStatus, 16'h0000);
        ioutSum[15:0] = 16'h012d;
        tick(1);
        chk({ocStatus, outputEnable}, 16'h0006);
        tick(1);
        chk(alertLineNOe, 16'h0001);
        ioutSum[15:0] = 16'h0000;
        tick(30);
        chk(outputEnable, 16'h0002);
        $display("latch test done");
        retry(8'hf8, 0);
        retry(8'hf9, 10);
        retry(8'hfe, 60);
        retry(8'hff, 70);
        $display("retry test done");
        host.wrReg(8'h47, 16'h0000, 1);
        host.wrReg(8'h44, 16'h0800, 2);
        host.rdReg(8'h44, d);
        chk(d, 16'h0800);
        railCycle;
        ioutSum[15:0] = 16'h0200;
        tick(3);
        chk({ocStatus[0], outputEnable[0]}, 16'h0003);
        ioutSum[15:0] = 16'h0000;
        railCycle;
        chk({ocStatus[0], alertLineNOe}, 16'h0000);
        rampActive[0] = 1'b1;
        voutMv[15:0] = 16'h0100;
        tick(4);
        chk(uvStatus[0], 16'h0000);
        rampActive[0] = 1'b0;
        tick(2);
        chk({uvStatus[0], outputEnable[0]}, 16'h0002);
        host.wrReg(8'h45, 16'h0000, 1);
        railCycle;
        chk({uvStatus[0], outputEnable[0]}, 16'h0003);
        otherShutdown = 2'h3;
        tick(2);
        chk(outputEnable, 16'h0000);
        chk(host.nackCount, 16'h0000);
        $display("fault test done");
        complete_run;
    end
endmodule // tb_ofr_fault_resp
